// ### design/modem_flow_pkg.sv
// Constants, field layout and carrier types for the modem status and auto flow block
package modem_flow_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_SCRATCH = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_FEATURE = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_XON1 = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_XON2 = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_XOFF1 = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_XOFF2 = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_HOST_RTS = 4'h9;
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DELTA_W = 4;
  localparam int BIT_CTS_CHANGED = 0;
  localparam int BIT_DSR_CHANGED = 1;
  localparam int BIT_RI_CHANGED = 2;
  localparam int BIT_CD_CHANGED = 3;
  localparam int BIT_AUTO_CTS = 7;
  localparam int BIT_AUTO_RTS = 6;
  localparam int BIT_ENHANCED = 4;
  localparam int FLD_RX_SEL_LSB = 0;
  localparam int FLD_TX_SEL_LSB = 2;
  localparam int BIT_HOST_RTS = 0;
  localparam int IRQ_W = 2;
  localparam int IRQ_MODEM = 0;
  localparam int IRQ_RX_TRIGGER = 1;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CHAR_NONE, CHAR_SECOND, CHAR_FIRST, CHAR_PAIR} char_select_type;

  // Packed so that bit 0 is CTS, matching the change-bit positions
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_lines_type;

  typedef struct packed {
    logic enhanced;
    char_select_type txSelect;
    char_select_type rxSelect;
  } sw_flow_type;

  typedef struct packed {
    logic atTrigger;
    logic atNextTrigger;
    logic belowLower;
  } rx_level_type;

endpackage : modem_flow_pkg

// ### design/modem_status_autoflow.sv
// Modem status change detection, scratch store and auto flow control for one channel
//
// Summary of operation
// (RULE1) DSR change sets change bit one
// (RULE2) CTS change sets change bit zero
// (RULE3) Any set change bit raises modem interrupt
// (RULE4) Status read clears the four change bits
// (RULE5) CD any change; RI only rising
// (RULE6) Scratch store holds eight host bits
// (RULE7) Low five feature bits pick character mode
// (RULE8) Paired characters form one sixteen-bit sequence
// (RULE9) Auto CTS halts on high pin
// (RULE10) Current character finishes before halting
// (RULE11) Auto CTS off after reset, ungated
// (RULE12) Auto RTS interrupts at trigger level
// (RULE13) Auto RTS raises pin at next level
// (RULE14) Auto RTS lowers pin below lower level
// (RULE15) Without auto RTS, host drives RTS
// (RULE16) Auto RTS bit reads live flow state
// (RULE17) Auto RTS off after reset
// (RULE18) Inputs synchronised, changes found by comparison
// (RULE19) Modem raises CTS only when full
`timescale 1ns/100ps
module modem_status_autoflow
  import modem_flow_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  // Modem control pins, active low, asynchronous
  input wire modem_lines_type modemPinsN,
  output logic rtsPinN,
  // Receive FIFO trigger crossings and transmitter
  input wire rx_level_type rxLevel,
  input wire logic fifoMode,
  input wire logic txCharBusy,
  output logic txHalt,
  // Software flow control selection
  output sw_flow_type swFlow,
  output logic [2*DATA_W-1:0] xonSequence,
  output logic [2*DATA_W-1:0] xoffSequence,
  // Interrupts
  output logic modemIrq,
  output logic irq
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic char_select_type selDecode(input logic [1:0] code);
    char_select_type sel;
    sel = CHAR_NONE;
    unique case (code)
      2'h0: sel = CHAR_NONE;
      2'h1: sel = CHAR_SECOND;
      2'h2: sel = CHAR_FIRST;
      2'h3: sel = CHAR_PAIR;
    endcase
    selDecode = sel;
  endfunction : selDecode

  logic [DATA_W-1:0] scratch_reg;
  logic [DATA_W-1:0] feature_reg;
  logic [DATA_W-1:0] xon1_reg;
  logic [DATA_W-1:0] xon2_reg;
  logic [DATA_W-1:0] xoff1_reg;
  logic [DATA_W-1:0] xoff2_reg;
  logic [DATA_W-1:0] hostRts_reg;
  logic [IRQ_W-1:0] irqMask_reg;
  logic [IRQ_W-1:0] irqStatus_reg;
  logic [IRQ_W-1:0] irqStatus_next;
  logic [DELTA_W-1:0] delta_reg;
  logic [DELTA_W-1:0] delta_next;
  logic [DELTA_W-1:0] deltaSet;
  modem_lines_type linesMeta_reg;
  modem_lines_type linesSync_reg;
  modem_lines_type linesPrev_reg;
  modem_lines_type linesChanged;
  logic atTriggerPrev_reg;
  logic autoCts;
  logic autoRtsActive;
  logic statusRead;
  logic [IRQ_W-1:0] irqEvents;

  assign autoCts = feature_reg[BIT_AUTO_CTS];
  assign autoRtsActive = feature_reg[BIT_AUTO_RTS] & fifoMode; // [RULE16]
  assign statusRead = regRead & hit(regAddr, OFF_STATUS);

  // ----------------------------------------------------------------
  // Modem line synchroniser and change detect
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      linesMeta_reg <= '1;
      linesSync_reg <= '1;
      linesPrev_reg <= '1;
    end else begin
      linesMeta_reg <= modemPinsN; // [RULE18]
      linesSync_reg <= linesMeta_reg;
      linesPrev_reg <= linesSync_reg;
    end
  end

  assign linesChanged = linesSync_reg ^ linesPrev_reg; // [RULE18]

  always_comb begin
    deltaSet = '0;
    deltaSet[BIT_CTS_CHANGED] = linesChanged.cts; // [RULE2]
    deltaSet[BIT_DSR_CHANGED] = linesChanged.dsr; // [RULE1]
    deltaSet[BIT_CD_CHANGED] = linesChanged.cd; // [RULE5]
    deltaSet[BIT_RI_CHANGED] = ~linesPrev_reg.ri & linesSync_reg.ri; // [RULE5]
  end

  // Set wins over the read clear so no change is lost
  assign delta_next = (statusRead ? '0 : delta_reg) | deltaSet; // [RULE4]

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      delta_reg <= '0;
    end else begin
      delta_reg <= delta_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      modemIrq <= 1'b0;
    end else begin
      modemIrq <= |delta_next; // [RULE3]
    end
  end

  chk_dsr_change: assert property (
    (linesChanged.dsr) |=> delta_reg[BIT_DSR_CHANGED]) // [RULE1]
    else $error("DSR change not flagged");

  chk_cts_change: assert property (
    (linesChanged.cts) |=> delta_reg[BIT_CTS_CHANGED]) // [RULE2]
    else $error("CTS change not flagged");

  chk_modem_irq: assert property (
    ##1 (modemIrq == (|delta_reg))) // [RULE3]
    else $error("Modem interrupt disagrees with change bits");

  chk_read_clears: assert property (
    (statusRead && linesChanged == '0) |=> (delta_reg == '0)) // [RULE4]
    else $error("Status read did not clear change bits");

  chk_ri_fall_ignored: assert property (
    (!delta_reg[BIT_RI_CHANGED] && linesPrev_reg.ri && !linesSync_reg.ri)
      |=> !delta_reg[BIT_RI_CHANGED]) // [RULE5]
    else $error("RI falling edge set change bit");

  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scratch_reg <= RESET_BYTE;
    end else if (regWrite && hit(regAddr, OFF_SCRATCH)) begin
      scratch_reg <= regWrData; // [RULE6]
    end
  end

  // Feature bits 7 and 6 reset clear, so both automatic modes start off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      feature_reg <= RESET_BYTE; // [RULE11] [RULE17]
    end else if (regWrite && hit(regAddr, OFF_FEATURE)) begin
      feature_reg <= regWrData;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      xon1_reg <= RESET_BYTE;
      xon2_reg <= RESET_BYTE;
      xoff1_reg <= RESET_BYTE;
      xoff2_reg <= RESET_BYTE;
    end else if (regWrite) begin
      if (hit(regAddr, OFF_XON1)) xon1_reg <= regWrData;
      if (hit(regAddr, OFF_XON2)) xon2_reg <= regWrData;
      if (hit(regAddr, OFF_XOFF1)) xoff1_reg <= regWrData;
      if (hit(regAddr, OFF_XOFF2)) xoff2_reg <= regWrData;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hostRts_reg <= RESET_BYTE;
      irqMask_reg <= '0;
    end else if (regWrite) begin
      if (hit(regAddr, OFF_HOST_RTS)) hostRts_reg <= regWrData;
      if (hit(regAddr, OFF_IRQ_MASK)) irqMask_reg <= regWrData[IRQ_W-1:0];
    end
  end

  // Read data stands for the one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData <= RESET_BYTE;
    end else if (regRead) begin
      unique case (1'b1)
        hit(regAddr, OFF_STATUS):
          regRdData <= {~linesSync_reg.cd, ~linesSync_reg.ri, ~linesSync_reg.dsr,
                        ~linesSync_reg.cts, delta_reg};
        hit(regAddr, OFF_SCRATCH): regRdData <= scratch_reg; // [RULE6]
        hit(regAddr, OFF_FEATURE): begin
          regRdData <= feature_reg;
          regRdData[BIT_AUTO_RTS] <= autoRtsActive; // [RULE16]
        end
        hit(regAddr, OFF_XON1): regRdData <= xon1_reg;
        hit(regAddr, OFF_XON2): regRdData <= xon2_reg;
        hit(regAddr, OFF_XOFF1): regRdData <= xoff1_reg;
        hit(regAddr, OFF_XOFF2): regRdData <= xoff2_reg;
        hit(regAddr, OFF_IRQ_STATUS): regRdData <= {{(DATA_W-IRQ_W){1'b0}}, irqStatus_reg};
        hit(regAddr, OFF_IRQ_MASK): regRdData <= {{(DATA_W-IRQ_W){1'b0}}, irqMask_reg};
        hit(regAddr, OFF_HOST_RTS): regRdData <= hostRts_reg;
        default: regRdData <= RESET_BYTE;
      endcase
    end else begin
      regRdData <= RESET_BYTE;
    end
  end

  sequence scratchWrite;
    regWrite && hit(regAddr, OFF_SCRATCH);
  endsequence

  sequence scratchReadNext;
    ##1 (regRead && hit(regAddr, OFF_SCRATCH) && !regWrite);
  endsequence

  chk_scratch_roundtrip: assert property (
    scratchWrite ##0 scratchReadNext |=> (regRdData == $past(regWrData, 2))) // [RULE6]
    else $error("Scratch store did not return written value");

  chk_auto_rts_read: assert property (
    (regRead && hit(regAddr, OFF_FEATURE)) |=>
      (regRdData[BIT_AUTO_RTS] == $past(autoRtsActive))) // [RULE16]
    else $error("Auto RTS bit does not show flow state");

  // ----------------------------------------------------------------
  // Software flow control selection
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      swFlow <= '{enhanced: 1'b0, txSelect: CHAR_NONE, rxSelect: CHAR_NONE};
      xonSequence <= '0;
      xoffSequence <= '0;
    end else begin
      swFlow.enhanced <= feature_reg[BIT_ENHANCED]; // [RULE7]
      swFlow.txSelect <= selDecode(feature_reg[FLD_TX_SEL_LSB +: 2]); // [RULE7]
      swFlow.rxSelect <= selDecode(feature_reg[FLD_RX_SEL_LSB +: 2]); // [RULE7]
      // The pair is always presented; the mode says how much of it is used
      xonSequence <= {xon1_reg, xon2_reg}; // [RULE8]
      xoffSequence <= {xoff1_reg, xoff2_reg}; // [RULE8]
    end
  end

  chk_pair_concat: assert property (
    ##1 (xonSequence == $past({xon1_reg, xon2_reg}) &&
         xoffSequence == $past({xoff1_reg, xoff2_reg}))) // [RULE8]
    else $error("Character pair not concatenated");

  // ----------------------------------------------------------------
  // Automatic CTS transmit hold
  // ----------------------------------------------------------------
  // A synchronised high CTS pin means the modem cannot accept more.
  // Hold is only raised between characters so a frame is never cut;
  // release is immediate since resuming early is harmless.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txHalt <= 1'b0;
    end else if (!autoCts || !linesSync_reg.cts) begin
      txHalt <= 1'b0; // [RULE9] [RULE11]
    end else if (!txCharBusy) begin
      txHalt <= 1'b1; // [RULE9] [RULE10] [RULE19]
    end
  end

  chk_cts_halt: assert property (
    (autoCts && linesSync_reg.cts && !txCharBusy) |=> txHalt) // [RULE9]
    else $error("Auto CTS did not halt transmitter");

  chk_char_finishes: assert property (
    (!txHalt && txCharBusy) |=> !txHalt) // [RULE10]
    else $error("Halt raised during a character");

  chk_cts_ungated: assert property (
    (!autoCts) |=> !txHalt) // [RULE11]
    else $error("Halt while auto CTS disabled");

  // ----------------------------------------------------------------
  // Automatic RTS and receive trigger interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      atTriggerPrev_reg <= 1'b0;
    end else begin
      atTriggerPrev_reg <= rxLevel.atTrigger;
    end
  end

  // Pin high means stop; host bit one asks the pin low in normal mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rtsPinN <= 1'b1;
    end else if (!autoRtsActive) begin
      rtsPinN <= ~hostRts_reg[BIT_HOST_RTS]; // [RULE15]
    end else if (rxLevel.atNextTrigger) begin
      rtsPinN <= 1'b1; // [RULE13]
    end else if (rxLevel.belowLower) begin
      rtsPinN <= 1'b0; // [RULE14]
    end
  end

  sequence autoFull;
    autoRtsActive && rxLevel.atNextTrigger;
  endsequence

  sequence autoDrained;
    autoRtsActive && !rxLevel.atNextTrigger && rxLevel.belowLower;
  endsequence

  chk_rts_raise: assert property (autoFull |=> rtsPinN) // [RULE13]
    else $error("Auto RTS did not raise pin");

  chk_rts_release: assert property (autoDrained |=> !rtsPinN) // [RULE14]
    else $error("Auto RTS did not release pin");

  chk_rts_host: assert property (
    (!autoRtsActive) |=> (rtsPinN == !$past(hostRts_reg[BIT_HOST_RTS]))) // [RULE15]
    else $error("RTS pin not under host control");

  assign irqEvents[IRQ_MODEM] = |deltaSet;
  assign irqEvents[IRQ_RX_TRIGGER] = autoRtsActive & rxLevel.atTrigger
                                     & ~atTriggerPrev_reg; // [RULE12]

  // Write one to clear; a new event in the same cycle keeps its bit
  always_comb begin
    irqStatus_next = irqStatus_reg;
    if (regWrite && hit(regAddr, OFF_IRQ_STATUS)) begin
      irqStatus_next = irqStatus_reg & ~regWrData[IRQ_W-1:0];
    end
    irqStatus_next = irqStatus_next | irqEvents;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqStatus_reg <= '0;
      irq <= 1'b0;
    end else begin
      irqStatus_reg <= irqStatus_next;
      irq <= |(irqStatus_next & irqMask_reg);
    end
  end

  chk_rx_trigger_irq: assert property (
    (autoRtsActive && rxLevel.atTrigger && !atTriggerPrev_reg)
      |=> irqStatus_reg[IRQ_RX_TRIGGER]) // [RULE12]
    else $error("Trigger level event not recorded");

  chk_auto_rts_reset: assert property (
    $fell(rst) |-> !feature_reg[BIT_AUTO_RTS] && !feature_reg[BIT_AUTO_CTS]) // [RULE17]
    else $error("Auto flow enabled after reset");

endmodule : modem_status_autoflow

// ### dv/modem_partner.sv
// Behavioural modem that drives the control lines and watches the returned RTS level
`timescale 1ns/100ps
module modem_partner
  import modem_flow_pkg::*;
#(
  parameter int CTS_LAG = 2
)
(
  // Clock
  input wire logic sys_clk,
  // Bench controls
  input wire logic full,
  input wire logic [2:0] otherPinsN,
  // Modem pins
  input wire logic rtsPinN,
  output modem_lines_type modemPinsN,
  output logic peerStopped
);
  // ----------------------------------------------------------------
  // Lines toward the device
  // ----------------------------------------------------------------
  logic [CTS_LAG:0] ctsPipe;

  // A real modem reacts late, so CTS trails the full condition
  always_ff @(posedge sys_clk) begin
    ctsPipe <= {ctsPipe[CTS_LAG-1:0], full};
  end

  // CTS high only while this end cannot take more characters
  assign modemPinsN = {otherPinsN, ctsPipe[CTS_LAG]};

  // Modem holds its own traffic while RTS asks it to stop
  always_ff @(posedge sys_clk) begin
    peerStopped <= rtsPinN;
  end
endmodule : modem_partner

// ### dv/modem_status_autoflow_tb.sv
// Self-checking testbench for the modem status and auto flow block
`timescale 1ns/100ps
module modem_status_autoflow_tb;
  import modem_flow_pkg::*;
  logic sys_clk, rst, regWrite, regRead, fifoMode, txCharBusy, txHalt;
  logic rtsPinN, modemIrq, irq, full, peerStopped;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData;
  logic [2:0] otherPinsN;
  logic [15:0] xonSequence, xoffSequence, x, y;
  modem_lines_type modemPinsN;
  rx_level_type rxLevel;
  sw_flow_type swFlow;
  logic [3:0] curPins, delta;
  logic [1:0] irqStat, irqMask;
  logic [7:0] s;
  int n_errors, tests_run;

  modem_status_autoflow i_modem_status_autoflow (.sys_clk(sys_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .modemPinsN(modemPinsN), .rtsPinN(rtsPinN), .rxLevel(rxLevel),
    .fifoMode(fifoMode), .txCharBusy(txCharBusy), .txHalt(txHalt), .swFlow(swFlow),
    .xonSequence(xonSequence), .xoffSequence(xoffSequence), .modemIrq(modemIrq), .irq(irq));

  modem_partner i_modem_partner (.sys_clk(sys_clk), .full(full), .otherPinsN(otherPinsN),
    .rtsPinN(rtsPinN), .modemPinsN(modemPinsN), .peerStopped(peerStopped));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_errors++;
    end
  endtask : cmp

  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    if (a == OFF_IRQ_STATUS) irqStat = irqStat & ~d[1:0];
    if (a == OFF_IRQ_MASK) irqMask = d[1:0];
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    cmp(what, {8'h00, exp}, {8'h00, regRdData});
  endtask : rd

  // Status read returns inverted lines above the change bits and clears them
  task automatic rdStatus;
    rd(OFF_STATUS, {~curPins, delta}, "status");
    delta = 4'h0;
    settle();
    cmp("modemIrq after read", 16'h0, {15'h0, modemIrq});
  endtask : rdStatus

  task automatic setPins(input logic [3:0] p);
    logic [3:0] ev;
    ev = ((p ^ curPins) & 4'hb) | {1'b0, ~curPins[2] & p[2], 2'b00};
    if (ev != 4'h0) irqStat[0] = 1'b1;
    delta = delta | ev;
    curPins = p;
    @(posedge sys_clk);
    full <= p[0];
    otherPinsN <= p[3:1];
    repeat (8) @(posedge sys_clk);
    #1;
    cmp("modemIrq", {15'h0, delta != 4'h0}, {15'h0, modemIrq});
  endtask : setPins

  task automatic chkIrq;
    settle();
    cmp("irq", {15'h0, |(irqStat & irqMask)}, {15'h0, irq});
  endtask : chkIrq

  task end_of_test;
    $display("checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    #100000;
    $display("unexpected run length: expected end, seen timeout");
    n_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    fifoMode = 1'b0;
    txCharBusy = 1'b0;
    rxLevel = 3'b000;
    full = 1'b1;
    otherPinsN = 3'h7;
    curPins = 4'hf;
    delta = 4'h0;
    irqStat = 2'h0;
    irqMask = 2'h0;
    n_errors = 0;
    tests_run = 0;
    void'($urandom(70758));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    cmp("outputs after reset", 16'h0008, {12'h0, rtsPinN, txHalt, modemIrq, irq});
    for (int a = 0; a < 16; a++) rd(4'(a), RESET_BYTE, "reset value");
    for (int i = 0; i < 4; i++) begin
      s = 8'($urandom);
      wr(OFF_SCRATCH, s);
      rd(OFF_SCRATCH, s, "scratch");
      // Write then read with no gap, the case the round-trip check watches
      s = ~s;
      @(posedge sys_clk);
      regAddr <= OFF_SCRATCH;
      regWrData <= s;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1;
      cmp("scratch back to back", {8'h00, s}, {8'h00, regRdData});
    end
    x = 16'($urandom);
    y = 16'($urandom);
    wr(OFF_XON1, x[15:8]);
    wr(OFF_XON2, x[7:0]);
    wr(OFF_XOFF1, y[15:8]);
    wr(OFF_XOFF2, y[7:0]);
    settle();
    cmp("xonSequence", x, xonSequence);
    cmp("xoffSequence", y, xoffSequence);
    for (int c = 0; c < 32; c++) begin
      wr(OFF_FEATURE, 8'(c));
      settle();
      cmp("swFlow", 16'(c), {11'h0, swFlow});
    end
    wr(OFF_FEATURE, 8'h00);
    // Each line away from idle and back; RI only flags its return
    for (int b = 0; b < 4; b++) begin
      setPins(curPins ^ (4'h1 << b));
      rdStatus();
      setPins(curPins ^ (4'h1 << b));
      rdStatus();
    end
    repeat (8) begin
      setPins(4'($urandom));
      rdStatus();
    end
    // Interrupt status, mask and write-one-to-clear
    wr(OFF_IRQ_STATUS, 8'h03);
    wr(OFF_IRQ_MASK, 8'h01);
    setPins(curPins ^ 4'h1);
    chkIrq();
    rd(OFF_IRQ_STATUS, {6'h0, irqStat}, "irq status");
    wr(OFF_IRQ_MASK, 8'h00);
    chkIrq();
    rd(OFF_IRQ_MASK, 8'h00, "irq mask");
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_IRQ_STATUS, 8'h01);
    chkIrq();
    rd(OFF_IRQ_STATUS, {6'h0, irqStat}, "irq status cleared");
    rdStatus();
    // Auto CTS: in-flight character completes before the halt
    setPins({curPins[3:1], 1'b0});
    wr(OFF_FEATURE, 8'h80);
    @(posedge sys_clk);
    txCharBusy <= 1'b1;
    setPins({curPins[3:1], 1'b1});
    cmp("txHalt while busy", 16'h0, {15'h0, txHalt});
    @(posedge sys_clk);
    txCharBusy <= 1'b0;
    settle();
    cmp("txHalt on cts high", 16'h1, {15'h0, txHalt});
    setPins({curPins[3:1], 1'b0});
    cmp("txHalt on cts low", 16'h0, {15'h0, txHalt});
    wr(OFF_FEATURE, 8'h00);
    setPins({curPins[3:1], 1'b1});
    cmp("txHalt auto cts off", 16'h0, {15'h0, txHalt});
    rdStatus();
    // Auto RTS driven by receive fill crossings
    @(posedge sys_clk);
    fifoMode <= 1'b1;
    wr(OFF_FEATURE, 8'h40);
    rd(OFF_FEATURE, 8'h40, "feature auto rts");
    @(posedge sys_clk);
    fifoMode <= 1'b0;
    rd(OFF_FEATURE, 8'h00, "feature flow off");
    @(posedge sys_clk);
    fifoMode <= 1'b1;
    rxLevel <= 3'b001;
    settle();
    cmp("rtsPinN below lower", 16'h0, {15'h0, rtsPinN});
    @(posedge sys_clk);
    rxLevel <= 3'b100;
    irqStat[1] = 1'b1;
    rd(OFF_IRQ_STATUS, {6'h0, irqStat}, "trigger irq");
    @(posedge sys_clk);
    rxLevel <= 3'b110;
    settle();
    cmp("rtsPinN next level", 16'h1, {15'h0, rtsPinN});
    cmp("peerStopped", 16'h1, {15'h0, peerStopped});
    @(posedge sys_clk);
    rxLevel <= 3'b100;
    settle();
    cmp("rtsPinN hold", 16'h1, {15'h0, rtsPinN});
    @(posedge sys_clk);
    rxLevel <= 3'b001;
    settle();
    cmp("rtsPinN drained", 16'h0, {15'h0, rtsPinN});
    // Host control of RTS once the automatic mode is off
    wr(OFF_FEATURE, 8'h00);
    wr(OFF_HOST_RTS, 8'h01);
    @(posedge sys_clk);
    rxLevel <= 3'b010;
    settle();
    cmp("rtsPinN host on", 16'h0, {15'h0, rtsPinN});
    wr(OFF_HOST_RTS, 8'h00);
    settle();
    cmp("rtsPinN host off", 16'h1, {15'h0, rtsPinN});
    end_of_test();
  end
endmodule : modem_status_autoflow_tb
